/* File: verilog/fbx_pkg.sv */
// constants, field layouts and carrier types for the flag-branch / bit / shift execution slice
package fbx_pkg;

    // bus geometry
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_INSTR  = 9'h000;
    localparam logic [ADDR_W-1:0] OFS_PC     = 9'h004;
    localparam logic [ADDR_W-1:0] OFS_SREG   = 9'h008;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 9'h00c;
    localparam logic [ADDR_W-1:0] OFS_IO     = 9'h080;
    localparam logic [ADDR_W-1:0] OFS_GPR    = 9'h100;
    localparam logic [ADDR_W-1:0] BANK_MASK  = 9'h180;

    // core geometry
    localparam int PC_W   = 12;
    localparam int K_W    = 7;
    localparam int IDX_W  = 5;
    localparam int BANK_N = 32;

    // status flag positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;
    localparam int FLG_I = 7;

    // status register fields
    localparam int ST_BUSY    = 0;
    localparam int ST_TAKEN   = 1;
    localparam int ST_ILLEGAL = 2;
    localparam int ST_CYC_LO  = 4;

    // reset values
    localparam logic [PC_W-1:0] PC_RST   = 12'h000;
    localparam logic [7:0]      SREG_RST = 8'h00;
    localparam logic [7:0]      BYTE_RST = 8'h00;

    // opcodes in the instruction register
    localparam logic [3:0] OP_BR_HALFCARRY_CLEAR = 4'h1;
    localparam logic [3:0] OP_BR_TRANSFER_SET    = 4'h2;
    localparam logic [3:0] OP_BR_TRANSFER_CLEAR  = 4'h3;
    localparam logic [3:0] OP_BR_OVERFLOW_SET    = 4'h4;
    localparam logic [3:0] OP_BR_OVERFLOW_CLEAR  = 4'h5;
    localparam logic [3:0] OP_BR_IRQ_ENABLED     = 4'h6;
    localparam logic [3:0] OP_BR_IRQ_DISABLED    = 4'h7;
    localparam logic [3:0] OP_IO_BIT_SET         = 4'h8;
    localparam logic [3:0] OP_IO_BIT_CLEAR       = 4'h9;
    localparam logic [3:0] OP_SHIFT_LEFT_LOGICAL = 4'ha;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // instruction word as written to the instruction register
    typedef struct packed {
        logic [2:0]       pad3;
        logic [IDX_W-1:0] rd;
        logic [2:0]       pad2;
        logic [IDX_W-1:0] io_addr;
        logic             pad1;
        logic [2:0]       bit_sel;
        logic             pad0;
        logic [K_W-1:0]   k;
        logic [3:0]       op;
    } fbx_instr_t;

    // register selected by an address
    typedef enum logic [2:0] {
        SEL_INSTR, SEL_PC, SEL_SREG, SEL_STATUS, SEL_IO, SEL_GPR, SEL_NONE
    } fbx_sel_t;

endpackage : fbx_pkg

/* File: verilog/fbx_top.sv */
// flag-branch, io bit set/clear and shift-left execution slice with an axi4-lite register port
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module fbx_top (
    input  wire logic                        CLK,
    input  wire logic                        RST_N,
    input  wire logic [fbx_pkg::ADDR_W-1:0]  AWADDR,
    input  wire logic                        AWVALID,
    output logic                             AWREADY,
    input  wire logic [fbx_pkg::DATA_W-1:0]  WDATA,
    input  wire logic [3:0]                  WSTRB,
    input  wire logic                        WVALID,
    output logic                             WREADY,
    output logic [1:0]                       BRESP,
    output logic                             BVALID,
    input  wire logic                        BREADY,
    input  wire logic [fbx_pkg::ADDR_W-1:0]  ARADDR,
    input  wire logic                        ARVALID,
    output logic                             ARREADY,
    output logic [fbx_pkg::DATA_W-1:0]       RDATA,
    output logic [1:0]                       RRESP,
    output logic                             RVALID,
    input  wire logic                        RREADY,
    output logic                             BUSY
);
    import fbx_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_EXEC, S_TAKEN} fbx_state_t;

    // map a byte address to the register it selects
    function automatic fbx_sel_t decode(input logic [ADDR_W-1:0] a);
        fbx_sel_t s;
        s = SEL_NONE;
        if (a[1:0] != 2'b00) s = SEL_NONE;
        else if ((a & BANK_MASK) == OFS_IO) s = SEL_IO;
        else if ((a & BANK_MASK) == OFS_GPR) s = SEL_GPR;
        else if (a == OFS_INSTR) s = SEL_INSTR;
        else if (a == OFS_PC) s = SEL_PC;
        else if (a == OFS_SREG) s = SEL_SREG;
        else if (a == OFS_STATUS) s = SEL_STATUS;
        return s;
    endfunction : decode

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction : merge

    // is this opcode one of the conditional branches
    function automatic logic is_branch(input logic [3:0] op);
        return (op >= OP_BR_HALFCARRY_CLEAR) && (op <= OP_BR_IRQ_DISABLED);
    endfunction : is_branch

    // branch condition against the flags
    function automatic logic cond_met(input logic [3:0] op, input logic [7:0] f);
        logic c;
        c = 1'b0;
        case (op)
            OP_BR_HALFCARRY_CLEAR: c = !f[FLG_H];
            OP_BR_TRANSFER_SET:    c = f[FLG_T];
            OP_BR_TRANSFER_CLEAR:  c = !f[FLG_T];
            OP_BR_OVERFLOW_SET:    c = f[FLG_V];
            OP_BR_OVERFLOW_CLEAR:  c = !f[FLG_V];
            OP_BR_IRQ_ENABLED:     c = f[FLG_I];
            OP_BR_IRQ_DISABLED:    c = !f[FLG_I];
            default:               c = 1'b0;
        endcase
        return c;
    endfunction : cond_met

    logic                  awready_q, wready_q, aw_have_q, w_have_q;
    logic [ADDR_W-1:0]     aw_addr_q;
    logic [DATA_W-1:0]     w_data_q;
    logic [3:0]            w_strb_q;
    logic                  bvalid_q, arready_q, rvalid_q, busy_q;
    logic [1:0]            bresp_q, rresp_q;
    logic [DATA_W-1:0]     rdata_q;
    fbx_state_t            state_q;
    fbx_instr_t            instr_q;
    logic [PC_W-1:0]       pc_q;
    logic [7:0]            sreg_q;
    logic [7:0]            io_q [BANK_N];
    logic [7:0]            gpr_q [BANK_N];
    logic                  taken_q, illegal_q;
    logic [1:0]            cyc_q;
    logic                  wr_fire, wr_ok, sw_wr;
    fbx_sel_t              wr_sel;
    logic [IDX_W-1:0]      wr_idx;
    logic                  do_sbi, do_cbi, do_lsl;
    logic [7:0]            lsl_src, lsl_res;
    logic [PC_W-1:0]       k_ext;

    // a write completes once both address and data are held
    assign wr_fire = aw_have_q && w_have_q;
    assign wr_sel  = decode(aw_addr_q);
    assign wr_idx  = aw_addr_q[IDX_W+1:2];
    // writes are refused while an instruction runs, so bus and execution never fight a register
    assign wr_ok   = !busy_q && (wr_sel != SEL_NONE) && (wr_sel != SEL_STATUS);
    assign sw_wr   = wr_fire && wr_ok;

    // execution strobes, valid only in the execute cycle
    assign do_sbi  = (state_q == S_EXEC) && (instr_q.op == OP_IO_BIT_SET);
    assign do_cbi  = (state_q == S_EXEC) && (instr_q.op == OP_IO_BIT_CLEAR);
    assign do_lsl  = (state_q == S_EXEC) && (instr_q.op == OP_SHIFT_LEFT_LOGICAL);
    assign lsl_src = gpr_q[instr_q.rd];
    assign lsl_res = {lsl_src[6:0], 1'b0};
    assign k_ext   = {{(PC_W-K_W){instr_q.k[K_W-1]}}, instr_q.k};

    // write address channel
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            awready_q <= 1'b1;
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (awready_q && AWVALID) begin
            awready_q <= 1'b0;
            aw_have_q <= 1'b1;
            aw_addr_q <= AWADDR;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end else if (bvalid_q && BREADY) begin
            awready_q <= 1'b1;  // one write in flight: reopen only after the response
        end
    end

    // write data channel
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wready_q <= 1'b1;
            w_have_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= 4'h0;
        end else if (wready_q && WVALID) begin
            wready_q <= 1'b0;
            w_have_q <= 1'b1;
            w_data_q <= WDATA;
            w_strb_q <= WSTRB;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end else if (bvalid_q && BREADY) begin
            wready_q <= 1'b1;
        end
    end

    // write response
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // read channel: data sampled at the address handshake
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else if (arready_q && ARVALID) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= '0;
            case (decode(ARADDR))
                SEL_INSTR:  rdata_q <= instr_q;
                SEL_PC:     rdata_q[PC_W-1:0] <= pc_q;
                SEL_SREG:   rdata_q[7:0] <= sreg_q;
                SEL_STATUS: rdata_q[ST_CYC_LO+1:0] <= {cyc_q, 1'b0, illegal_q, taken_q, busy_q};
                SEL_IO:     rdata_q[7:0] <= io_q[ARADDR[IDX_W+1:2]];
                SEL_GPR:    rdata_q[7:0] <= gpr_q[ARADDR[IDX_W+1:2]];
                default:    rresp_q <= RESP_SLVERR;
            endcase
        end else if (rvalid_q && RREADY) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // sequencer: issue on instruction write, then one or two execute cycles
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q   <= S_IDLE;
            busy_q    <= 1'b0;
            instr_q   <= '0;
            taken_q   <= 1'b0;
            illegal_q <= 1'b0;
            cyc_q     <= 2'd0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (sw_wr && wr_sel == SEL_INSTR) begin
                        instr_q <= fbx_instr_t'(merge(instr_q, w_data_q, w_strb_q));
                        state_q <= S_EXEC;
                        busy_q  <= 1'b1;
                    end
                end
                S_EXEC: begin
                    illegal_q <= !is_branch(instr_q.op) && !do_sbi && !do_cbi && !do_lsl;
                    if (is_branch(instr_q.op) && cond_met(instr_q.op, sreg_q)) begin
                        state_q <= S_TAKEN;
                        taken_q <= 1'b1;
                    end else begin
                        state_q <= S_IDLE;
                        busy_q  <= 1'b0;
                        taken_q <= 1'b0;
                        cyc_q   <= 2'd1;
                    end
                end
                S_TAKEN: begin
                    state_q <= S_IDLE;
                    busy_q  <= 1'b0;
                    cyc_q   <= 2'd2;
                end
                default: begin
                    state_q <= S_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // program counter: sequential step, taken branch, or software load
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pc_q <= PC_RST;
        end else if (state_q == S_TAKEN) begin
            pc_q <= pc_q + k_ext + PC_W'(1);
        end else if (state_q == S_EXEC && !(is_branch(instr_q.op) && cond_met(instr_q.op, sreg_q))) begin
            pc_q <= pc_q + PC_W'(1);  // falls through in sequence
        end else if (sw_wr && wr_sel == SEL_PC) begin
            pc_q <= PC_W'(merge(32'(pc_q), w_data_q, w_strb_q));
        end
    end

    // status flags: only the shift and a software write touch them; branches and bit ops leave them alone
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sreg_q <= SREG_RST;
        end else if (do_lsl) begin
            sreg_q[FLG_C] <= lsl_src[7];
            sreg_q[FLG_Z] <= (lsl_res == 8'h00);
            sreg_q[FLG_N] <= lsl_res[7];
            sreg_q[FLG_V] <= lsl_res[7] ^ lsl_src[7];
        end else if (sw_wr && wr_sel == SEL_SREG && w_strb_q[0]) begin
            sreg_q <= w_data_q[7:0];
        end
    end

    // io register bank and working register bank, one flop group per index
    for (genvar gi = 0; gi < BANK_N; gi++) begin : g_bank
        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                io_q[gi] <= BYTE_RST;
            end else if (do_sbi && instr_q.io_addr == IDX_W'(gi)) begin
                io_q[gi][instr_q.bit_sel] <= 1'b1;
            end else if (do_cbi && instr_q.io_addr == IDX_W'(gi)) begin
                io_q[gi][instr_q.bit_sel] <= 1'b0;
            end else if (sw_wr && wr_sel == SEL_IO && wr_idx == IDX_W'(gi) && w_strb_q[0]) begin
                io_q[gi] <= w_data_q[7:0];
            end
        end

        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                gpr_q[gi] <= BYTE_RST;
            end else if (do_lsl && instr_q.rd == IDX_W'(gi)) begin
                gpr_q[gi] <= lsl_res;
            end else if (sw_wr && wr_sel == SEL_GPR && wr_idx == IDX_W'(gi) && w_strb_q[0]) begin
                gpr_q[gi] <= w_data_q[7:0];
            end
        end
    end

    // outputs straight from flops
    assign AWREADY = awready_q;
    assign WREADY  = wready_q;
    assign BVALID  = bvalid_q;
    assign BRESP   = bresp_q;
    assign ARREADY = arready_q;
    assign RVALID  = rvalid_q;
    assign RDATA   = rdata_q;
    assign RRESP   = rresp_q;
    assign BUSY    = busy_q;

endmodule : fbx_top

/* File: verification/fbx_top_sva.sv */
// checker for the register port handshakes and busy timing of the execution slice
`timescale 1ns/1ps
module fbx_top_sva
    import fbx_pkg::*;
(
    input wire logic                       CLK,
    input wire logic                       RST_N,
    input wire logic [fbx_pkg::ADDR_W-1:0] AWADDR,
    input wire logic                       AWVALID,
    input wire logic                       AWREADY,
    input wire logic                       WVALID,
    input wire logic                       WREADY,
    input wire logic [1:0]                 BRESP,
    input wire logic                       BVALID,
    input wire logic                       BREADY,
    input wire logic [fbx_pkg::ADDR_W-1:0] ARADDR,
    input wire logic                       ARVALID,
    input wire logic                       ARREADY,
    input wire logic [fbx_pkg::DATA_W-1:0] RDATA,
    input wire logic [1:0]                 RRESP,
    input wire logic                       RVALID,
    input wire logic                       RREADY,
    input wire logic                       BUSY
);
    // one clock domain, so clocking and reset are stated once
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // an instruction never holds the core longer than a taken branch
    busy_two_max_a: assert property ($rose(BUSY) |-> ##[1:2] !BUSY)
        else $error("busy lasted more than two cycles");
    busy_from_write_a: assert property ($rose(BUSY) |-> $rose(BVALID))
        else $error("busy rose without a completed write");
    // address and data are held one cycle, the response follows at the next edge
    b_follows_aw_a: assert property (AWVALID && AWREADY && WVALID && WREADY |=> ##1 BVALID)
        else $error("write response not two cycles after address and data");
    aw_blocked_a: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write channels ready while a response is pending");
    b_release_a: assert property (BVALID && BREADY |=> !BVALID && AWREADY && WREADY)
        else $error("write response not retired after its handshake");
    r_follows_ar_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
        else $error("read data not one cycle after the address");
    r_release_a: assert property (RVALID && RREADY |=> !RVALID && ARREADY)
        else $error("read data not retired after its handshake");
    r_unaligned_a: assert property (ARVALID && ARREADY && ARADDR[1:0] != 2'b00
        |=> RRESP == RESP_SLVERR && RDATA == '0)
        else $error("unaligned read not refused");
    status_ro_a: assert property (AWVALID && AWREADY && WVALID && WREADY && AWADDR == OFS_STATUS
        |=> ##1 BRESP == RESP_SLVERR)
        else $error("write to status word not refused");
endmodule : fbx_top_sva

bind fbx_top fbx_top_sva fbx_top_sva_inst (.CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .BUSY(BUSY));

/* File: verification/test_flag_branch_bit_exec.sv */
// self-checking bench for the flag-branch, io bit and shift-left slice
`timescale 1ns/1ps
module test_flag_branch_bit_exec;
    import fbx_pkg::*;
    typedef struct packed {
        logic [3:0]     op;
        logic [7:0]     sreg;
        logic [K_W-1:0] k;
        logic           taken;
    } fbx_row_t;
    logic                CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic                AWREADY, WREADY, BVALID, ARREADY, RVALID, BUSY;
    logic [ADDR_W-1:0]   AWADDR, ARADDR;
    logic [DATA_W-1:0]   WDATA, RDATA, rdat;
    logic [3:0]          WSTRB;
    logic [1:0]          BRESP, RRESP;
    int                  fail_count, samples_checked;
    fbx_row_t            rows [14];
    logic [PC_W-1:0]     pc_x;
    logic [7:0]          v, res;
    logic [4:0]          p;

    fbx_top fbx_top_inst (.CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .BUSY(BUSY));

    // 50 ns period
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // write master: both channels offered together, bready held until the response
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge CLK);
        AWADDR  <= a;
        WDATA   <= d;
        AWVALID <= 1'b1;
        WVALID  <= 1'b1;
        BREADY  <= 1'b1;
        // no cycle count assumed: only the watchdog ends a hung wait
        while (!done) begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
            if (BVALID) begin
                done = 1'b1;
                BREADY <= 1'b0;
                check(32'(BRESP), 32'(er));
            end
        end
    endtask : wr

    // read master: result left in rdat
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge CLK);
        ARADDR  <= a;
        ARVALID <= 1'b1;
        RREADY  <= 1'b1;
        while (!done) begin
            @(posedge CLK);
            if (ARREADY) ARVALID <= 1'b0;
            if (RVALID) begin
                done = 1'b1;
                RREADY <= 1'b0;
                rdat = RDATA;
                check(32'(RRESP), 32'(er));
            end
        end
    endtask : rd

    function automatic logic [31:0] mk(input logic [3:0] op, input logic [6:0] k, input logic [2:0] b,
                                       input logic [4:0] pi, input logic [4:0] d);
        fbx_instr_t t;
        t = '0;
        t.op = op;
        t.k = k;
        t.bit_sel = b;
        t.io_addr = pi;
        t.rd = d;
        return t;
    endfunction : mk

    // issue one instruction and wait, with no timeout of its own, for busy to drop
    task automatic run(input logic [31:0] d);
        wr(OFS_INSTR, d, RESP_OKAY);
        while (BUSY !== 1'b0) @(posedge CLK);
    endtask : run

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge CLK);
        fail_count++;
        give_verdict();
    end

    initial begin
        {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
        {AWADDR, ARADDR, WDATA} = '0;
        WSTRB = 4'hf;
        // each flag test taken and not taken; k covers both signs and the pc wrap
        rows = '{'{4'h1, 8'h00, 7'h3f, 1'b1}, '{4'h1, 8'h20, 7'h3f, 1'b0}, '{4'h2, 8'h40, 7'h40, 1'b1},
                 '{4'h2, 8'h00, 7'h05, 1'b0}, '{4'h3, 8'hbf, 7'h7f, 1'b1}, '{4'h3, 8'h40, 7'h7f, 1'b0},
                 '{4'h4, 8'h08, 7'h01, 1'b1}, '{4'h4, 8'hf7, 7'h01, 1'b0}, '{4'h5, 8'hf7, 7'h00, 1'b1},
                 '{4'h5, 8'h08, 7'h10, 1'b0}, '{4'h6, 8'h80, 7'h20, 1'b1}, '{4'h6, 8'h7f, 7'h20, 1'b0},
                 '{4'h7, 8'h7f, 7'h55, 1'b1}, '{4'h7, 8'h80, 7'h55, 1'b0}};
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        rd(OFS_PC, RESP_OKAY);
        check(rdat & 32'hfff, 32'h0);
        rd(OFS_SREG, RESP_OKAY);
        check(rdat & 32'hff, 32'h0);
        $display("reset values done");
        foreach (rows[i]) begin
            wr(OFS_PC, 32'h010, RESP_OKAY);
            wr(OFS_SREG, {24'h0, rows[i].sreg}, RESP_OKAY);
            run(mk(rows[i].op, rows[i].k, 3'h0, 5'h0, 5'h0));
            pc_x = rows[i].taken ? 12'h011 + {{(PC_W-K_W){rows[i].k[K_W-1]}}, rows[i].k} : 12'h011;
            rd(OFS_PC, RESP_OKAY);
            check(rdat & 32'hfff, 32'(pc_x));
            rd(OFS_SREG, RESP_OKAY);
            check(rdat & 32'hff, 32'(rows[i].sreg));
            rd(OFS_STATUS, RESP_OKAY);
            // status: cycles in [5:4], taken in bit 1, busy in bit 0
            check(rdat & 32'h37, {26'h0, rows[i].taken ? 2'd2 : 2'd1, 2'b0, rows[i].taken, 1'b0});
            $display("branch row %0d done", i);
        end
        // io bit set then clear on each bit position; pc starts near the top to wrap
        wr(OFS_PC, 32'hffe, RESP_OKAY);
        wr(OFS_SREG, 32'h3c, RESP_OKAY);
        for (int b = 0; b < 8; b++) begin
            p = 5'(31 - 3 * b);
            wr(OFS_IO + ADDR_W'(4 * p), 32'ha5, RESP_OKAY);
            run(mk(OP_IO_BIT_SET, 7'h0, 3'(b), p, 5'h0));
            rd(OFS_IO + ADDR_W'(4 * p), RESP_OKAY);
            check(rdat & 32'hff, 32'(8'ha5 | (8'h01 << b)));
            run(mk(OP_IO_BIT_CLEAR, 7'h0, 3'(b), p, 5'h0));
            rd(OFS_IO + ADDR_W'(4 * p), RESP_OKAY);
            check(rdat & 32'hff, 32'(8'ha5 & ~(8'h01 << b)));
        end
        rd(OFS_SREG, RESP_OKAY);
        check(rdat & 32'hff, 32'h3c);
        rd(OFS_PC, RESP_OKAY);
        check(rdat & 32'hfff, 32'h00e);
        $display("io bit tests done");
        // shift: half-carry and sign flags must survive, the low four follow the result
        for (int j = 0; j < 5; j++) begin
            v = (j == 0) ? 8'h80 : (j == 1) ? 8'h41 : (j == 2) ? 8'hc3 : (j == 3) ? 8'h00 : 8'h7f;
            res = {v[6:0], 1'b0};
            wr(OFS_GPR + ADDR_W'(4 * (31 - 7 * j)), 32'(v), RESP_OKAY);
            wr(OFS_SREG, j[0] ? 32'h3f : 32'h30, RESP_OKAY);
            run(mk(OP_SHIFT_LEFT_LOGICAL, 7'h0, 3'h0, 5'h0, 5'(31 - 7 * j)));
            rd(OFS_GPR + ADDR_W'(4 * (31 - 7 * j)), RESP_OKAY);
            check(rdat & 32'hff, 32'(res));
            rd(OFS_SREG, RESP_OKAY);
            check(rdat & 32'hff, {24'h0, 4'h3, res[7] ^ v[7], res[7], res == 8'h00, v[7]});
        end
        $display("shift tests done");
        // unknown opcode, read-only status, unmapped and unaligned places
        wr(OFS_PC, 32'h123, RESP_OKAY);
        run(mk(4'h0, 7'h0, 3'h0, 5'h0, 5'h0));
        rd(OFS_STATUS, RESP_OKAY);
        check(rdat & 32'h4, 32'h4);
        rd(OFS_PC, RESP_OKAY);
        check(rdat & 32'hfff, 32'h124);
        wr(OFS_STATUS, 32'h0, RESP_SLVERR);
        rd(9'h184, RESP_SLVERR);
        check(rdat, 32'h0);
        rd(9'h002, RESP_SLVERR);
        check(rdat, 32'h0);
        $display("error cases done");
        // mid-run reset: status, pc and a bank entry written earlier return to zero
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        rd(OFS_STATUS, RESP_OKAY);
        check(rdat, 32'h0);
        rd(OFS_PC, RESP_OKAY);
        check(rdat, 32'h0);
        rd(OFS_IO + ADDR_W'(4 * 10), RESP_OKAY);
        check(rdat, 32'h0);
        $display("mid-run reset done");
        give_verdict();
    end
endmodule : test_flag_branch_bit_exec
